// [hdl/nvsc_host.sv]
// Host controller that runs read and write cycles on an asynchronous 8K x 8 NV SRAM
//
// Overview of operation
// - Address held steady through every write
// - Strobe high for recovery before next access
// - Enable kept high throughout writes
// - No accesses until supply is good
// - Write pulse at least 100 ns unless supply fails mid-write
// - Write data set up 60 ns before end unless supply fails mid-write
`timescale 1ns/1ns
`default_nettype none
`include "nvsc_params.svh"
module nvsc_host #(
	parameter int ADDR_W        = `NVSC_ADDR_W,
	parameter int DATA_W        = `NVSC_DATA_W,
	parameter int POWERUP_US    = `NVSC_POWERUP_US
) (
	input  wire logic                clk_sys,
	input  wire logic                resetn,
	input  wire logic                clk_en,
	input  wire logic                supply_good,
	input  wire logic                req_valid,
	input  wire nvsc_pkg::nvsc_req_t req,
	output logic                     req_ready,
	output logic                     rsp_valid,
	output logic [DATA_W-1:0]        rsp_rdata,
	output nvsc_pkg::nvsc_pins_t     pins,
	input  wire logic [DATA_W-1:0]   data_bus_i,
	output logic [DATA_W-1:0]        data_bus_o,
	output logic                     data_bus_oe
);
	localparam int ACC_CYC  = (`NVSC_ACCESS_TIME_NS + `NVSC_CLK_PERIOD_NS - 1) / `NVSC_CLK_PERIOD_NS;
	localparam int WP_CYC   = (`NVSC_WRITE_PULSE_NS + `NVSC_CLK_PERIOD_NS - 1) / `NVSC_CLK_PERIOD_NS;
	localparam int REC_CYC  = (`NVSC_WRITE_RECOVERY_NS + `NVSC_TRISTATE_NS + `NVSC_CLK_PERIOD_NS - 1)
		/ `NVSC_CLK_PERIOD_NS;
	localparam int PWR_CYC  = POWERUP_US * (1000 / `NVSC_CLK_PERIOD_NS);
	localparam logic [`NVSC_CNT_W-1:0] ACC_N = `NVSC_CNT_W'(ACC_CYC);
	localparam logic [`NVSC_CNT_W-1:0] WP_N  = `NVSC_CNT_W'(WP_CYC);
	localparam logic [`NVSC_CNT_W-1:0] REC_N = `NVSC_CNT_W'(REC_CYC);
	localparam logic [`NVSC_CNT_W-1:0] PWR_N = `NVSC_CNT_W'(PWR_CYC);

	// Widths are fixed by the memory organisation; the counter must hold the power-up wait
	if (ADDR_W != `NVSC_ADDR_W || DATA_W != `NVSC_DATA_W) begin : g_bad_width
		$error("nvsc_host: widths must match the memory organisation");
	end
	if (PWR_CYC < 1 || PWR_CYC >= (1 << `NVSC_CNT_W)) begin : g_bad_powerup
		$error("nvsc_host: power-up wait does not fit the counter");
	end

	// Supply flag comes from outside the clock domain
	logic sg_meta_q;
	logic sg_sync_q;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sg_meta_q <= 1'b0;
			sg_sync_q <= 1'b0;
		end else if (clk_en) begin
			sg_meta_q <= supply_good;
			sg_sync_q <= sg_meta_q;
		end
	end

	// Bus settles long before the sample point, so bitwise syncing cannot tear a byte
	logic [DATA_W-1:0] din_meta_q;
	logic [DATA_W-1:0] din_sync_q;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			din_meta_q <= '0;
			din_sync_q <= '0;
		end else if (clk_en) begin
			din_meta_q <= data_bus_i;
			din_sync_q <= din_meta_q;
		end
	end

	nvsc_pkg::nvsc_state_t   state_q, state_d;
	logic [`NVSC_CNT_W-1:0]  cnt_q, cnt_d;
	nvsc_pkg::nvsc_pins_t    pins_q, pins_d;
	logic [DATA_W-1:0]       dout_q, dout_d;
	logic                    oe_q, oe_d;
	logic                    rdy_q, rdy_d;
	logic                    rv_q, rv_d;
	logic [DATA_W-1:0]       rd_q, rd_d;

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		pins_d  = pins_q;
		dout_d  = dout_q;
		oe_d    = oe_q;
		rdy_d   = 1'b0;
		rv_d    = 1'b0;
		rd_d    = rd_q;
		unique case (state_q)
			nvsc_pkg::NVSC_BOOT: begin
				// Long settle time after the supply recovers
				pins_d.select_n = 1'b1;
				if (!sg_sync_q) begin
					cnt_d = '0;
				end else if (cnt_q >= PWR_N) begin
					state_d = nvsc_pkg::NVSC_IDLE;
					rdy_d   = 1'b1;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			nvsc_pkg::NVSC_IDLE: begin
				rdy_d = 1'b1;
				if (!sg_sync_q) begin
					state_d = nvsc_pkg::NVSC_BOOT;
					rdy_d   = 1'b0;
					cnt_d   = '0;
				end else if (req_valid && rdy_q) begin
					rdy_d               = 1'b0;
					cnt_d               = '0;
					pins_d.byte_address = req.addr[ADDR_W-1:0];
					pins_d.select_n     = 1'b0;
					if (req.write) begin
						// Address, data and strobe all move together; setup time is zero
						pins_d.strobe_n = 1'b0;
						pins_d.enable_n = 1'b1;
						dout_d          = req.wdata;
						oe_d            = 1'b1;
						state_d         = nvsc_pkg::NVSC_WRITE;
					end else begin
						pins_d.strobe_n = 1'b1;
						pins_d.enable_n = 1'b0;
						state_d         = nvsc_pkg::NVSC_READ;
					end
				end
			end
			nvsc_pkg::NVSC_READ: begin
				cnt_d = cnt_q + 1'b1;
				// Two extra cycles absorb the input synchroniser
				if (cnt_q >= ACC_N + `NVSC_CNT_W'(`NVSC_SYNC_CYC)) begin
					rd_d            = din_sync_q;
					rv_d            = 1'b1;
					pins_d.select_n = 1'b1;
					pins_d.enable_n = 1'b1;
					cnt_d           = '0;
					state_d         = nvsc_pkg::NVSC_RECOV;
				end
			end
			nvsc_pkg::NVSC_WRITE: begin
				cnt_d = cnt_q + 1'b1;
				// Pulse held well past the data setup, address frozen meanwhile
				if (cnt_q >= WP_N) begin
					pins_d.strobe_n = 1'b1;
					pins_d.select_n = 1'b1;
					cnt_d           = '0;
					state_d         = nvsc_pkg::NVSC_RECOV;
				end
			end
			nvsc_pkg::NVSC_RECOV: begin
				// Data held one cycle past the rising edge, then released
				oe_d  = 1'b0;
				cnt_d = cnt_q + 1'b1;
				if (cnt_q >= REC_N) begin
					state_d = nvsc_pkg::NVSC_IDLE;
					rdy_d   = sg_sync_q;
				end
			end
			default: begin
				state_d = nvsc_pkg::NVSC_BOOT;
				cnt_d   = '0;
			end
		endcase
		if (!sg_sync_q) begin
			// Supply failing: deselect at once, drop the cycle without a response
			// and restart the power-up wait, since the device ignores everything now
			state_d         = nvsc_pkg::NVSC_BOOT;
			cnt_d           = '0;
			pins_d.select_n = 1'b1;
			pins_d.strobe_n = 1'b1;
			pins_d.enable_n = 1'b1;
			oe_d            = 1'b0;
			rdy_d           = 1'b0;
			rv_d            = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_q <= nvsc_pkg::NVSC_BOOT;
			cnt_q   <= '0;
			pins_q  <= '{select_n: 1'b1, strobe_n: 1'b1, enable_n: 1'b1, byte_address: '0};
			dout_q  <= '0;
			oe_q    <= 1'b0;
			rdy_q   <= 1'b0;
			rv_q    <= 1'b0;
			rd_q    <= '0;
		end else if (clk_en) begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			pins_q  <= pins_d;
			dout_q  <= dout_d;
			oe_q    <= oe_d;
			rdy_q   <= rdy_d;
			rv_q    <= rv_d;
			rd_q    <= rd_d;
		end
	end

	assign req_ready   = rdy_q;
	assign rsp_valid   = rv_q;
	assign rsp_rdata   = rd_q;
	assign pins        = pins_q;
	assign data_bus_o  = dout_q;
	assign data_bus_oe = oe_q;
endmodule
`default_nettype wire

// [hdl/nvsc_params.svh]
// Timing and width constants for the nonvolatile SRAM host port controller
`ifndef NVSC_PARAMS_SVH
`define NVSC_PARAMS_SVH
`define NVSC_ADDR_W            13
`define NVSC_DATA_W            8
`define NVSC_CLK_PERIOD_NS     4
`define NVSC_ACCESS_TIME_NS    150
`define NVSC_ENABLE_ACCESS_NS  70
`define NVSC_WRITE_PULSE_NS    100
`define NVSC_DATA_SETUP_NS     60
`define NVSC_WRITE_RECOVERY_NS 10
`define NVSC_TRISTATE_NS       35
`define NVSC_POWERUP_US        2000
`define NVSC_CNT_W             20
`define NVSC_SYNC_CYC          2
`endif

// [hdl/nvsc_pkg.sv]
// Types shared by the nonvolatile SRAM host port controller
`default_nettype none
`include "nvsc_params.svh"
package nvsc_pkg;
	typedef enum logic [4:0] {
		NVSC_BOOT  = 5'h01,
		NVSC_IDLE  = 5'h02,
		NVSC_READ  = 5'h04,
		NVSC_WRITE = 5'h08,
		NVSC_RECOV = 5'h10
	} nvsc_state_t;
	typedef struct packed {
		logic                      write;
		logic [`NVSC_ADDR_W-1:0]   addr;
		logic [`NVSC_DATA_W-1:0]   wdata;
	} nvsc_req_t;
	typedef struct packed {
		logic                      select_n;
		logic                      strobe_n;
		logic                      enable_n;
		logic [`NVSC_ADDR_W-1:0]   byte_address;
	} nvsc_pins_t;
endpackage
`default_nettype wire

// [tb/nvsc_host_properties.sv]
// Checker for the pin rules kept by the host controller
`timescale 1ns/1ns
`default_nettype none
module nvsc_host_chk (
	input wire logic                 clk_sys,
	input wire logic                 resetn,
	input wire logic                 supply_good,
	input wire nvsc_pkg::nvsc_pins_t pins,
	input wire logic [7:0]           data_bus_o,
	input wire logic                 data_bus_oe
);
	logic       wr;
	logic [7:0] wcnt_q;
	logic [7:0] wcnt_d;
	assign wr = !pins.select_n && !pins.strobe_n;
	// Saturate so a stuck write cannot wrap and look short
	always_comb wcnt_d = wr ? ((wcnt_q == 8'hff) ? wcnt_q : wcnt_q + 8'h01) : 8'h00;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			wcnt_q <= 8'h00;
		else
			wcnt_q <= wcnt_d;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence wr_end;
		!wr && $past(wr);
	endsequence
	a_addr_hold_write: assert property (wr && $past(wr) |-> $stable(pins.byte_address))
		else $error("address moved in write");
	a_recovery_gap: assert property ($rose(pins.strobe_n) |-> (pins.strobe_n && pins.select_n) [*3])
		else $error("recovery too short");
	a_enable_high_write: assert property (!pins.strobe_n |-> pins.enable_n)
		else $error("enable low in write");
	a_no_access_low: assert property (!supply_good [*5] |-> pins.select_n)
		else $error("access with supply low");
	a_pulse_width: assert property (wr_end |-> !supply_good || wcnt_q >= 8'h19)
		else $error("write pulse short");
	a_data_steady: assert property (wr |-> data_bus_oe && ($stable(data_bus_o) || !$past(wr)))
		else $error("write data not steady");
endmodule
bind nvsc_host nvsc_host_chk u_chk (.clk_sys(clk_sys), .resetn(resetn), .supply_good(supply_good),
	.pins(pins), .data_bus_o(data_bus_o), .data_bus_oe(data_bus_oe));
`default_nettype wire

// [tb/nvsc_host_tb.sv]
// Self-checking bench for the NV SRAM host controller
`timescale 1ns/1ns
`default_nettype none
module nvsc_host_tb;
	logic                 clk_sys = 1'b0;
	logic                 resetn = 1'b0;
	logic                 supply_good = 1'b0;
	logic                 req_valid = 1'b0;
	nvsc_pkg::nvsc_req_t  req = '0;
	logic                 req_ready, rsp_valid, data_bus_oe;
	logic [7:0]           rsp_rdata, bus, data_bus_o;
	nvsc_pkg::nvsc_pins_t pins;
	logic                 clk_en = 1'b1;
	int                   err_total = 0;
	int                   n_tests = 0;
	always #2 clk_sys = ~clk_sys;
	nvsc_host #(.POWERUP_US(1)) dut (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
		.supply_good(supply_good), .req_valid(req_valid), .req(req), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .pins(pins), .data_bus_i(bus),
		.data_bus_o(data_bus_o), .data_bus_oe(data_bus_oe));
	nvsc_sram_model u_mem (.supply_good(supply_good), .pins(pins), .host_d(data_bus_o),
		.host_oe(data_bus_oe), .bus(bus));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Distinct byte per index so an address line that aliases shows up
	function automatic logic [7:0] pat(input int i);
		return {4'(i), ~4'(i)};
	endfunction
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic op(input logic w, input logic [12:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req <= '{write: w, addr: a, wdata: d};
		@(negedge clk_sys);
		while (req_ready !== 1'b1 && n < 600) begin
			@(negedge clk_sys);
			n++;
		end
		chk(req_ready, 1'b1);
		@(posedge clk_sys);
		req_valid <= 1'b0;
	endtask
	task automatic rd(input logic [12:0] a, input logic [7:0] exp);
		int n;
		n = 0;
		op(1'b0, a, 8'h00);
		while (rsp_valid !== 1'b1 && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		chk({7'h00, rsp_valid, rsp_rdata}, {8'h01, exp});
	endtask
	task automatic t_power;
		repeat (300) @(posedge clk_sys);
		chk({pins.select_n, req_ready}, 2'b10);
		supply_good <= 1'b1;
		repeat (200) @(posedge clk_sys);
		chk(req_ready, 1'b0);
		$display("power-up test done");
	endtask
	task automatic t_rw;
		op(1'b1, 13'h0000, pat(0));
		for (int b = 0; b < 13; b++)
			op(1'b1, 13'(1 << b), pat(b + 1));
		rd(13'h0000, pat(0));
		for (int b = 0; b < 13; b++)
			rd(13'(1 << b), pat(b + 1));
		$display("read-write test done");
	endtask
	task automatic t_freeze;
		int n;
		n = 0;
		op(1'b0, 13'h0000, 8'h00);
		repeat (5) @(posedge clk_sys);
		clk_en <= 1'b0;
		repeat (60) @(posedge clk_sys);
		@(negedge clk_sys);
		chk({pins.select_n, pins.enable_n, rsp_valid}, 3'b000);
		@(posedge clk_sys);
		clk_en <= 1'b1;
		while (rsp_valid !== 1'b1 && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		chk({7'h00, rsp_valid, rsp_rdata}, {8'h01, pat(0)});
		$display("clock-enable test done");
	endtask
	task automatic t_brown;
		op(1'b1, 13'h0400, 8'h11);
		repeat (5) @(posedge clk_sys);
		supply_good <= 1'b0;
		repeat (20) @(posedge clk_sys);
		chk({pins.select_n, data_bus_oe, req_ready}, 3'b100);
		supply_good <= 1'b1;
		repeat (100) @(posedge clk_sys);
		chk(req_ready, 1'b0);
		rd(13'h0400, pat(11));
		$display("brown-out test done");
	endtask
	initial begin
		#40000;
		err_total++;
		tally_and_finish();
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		resetn <= 1'b1;
		t_power();
		t_rw();
		t_freeze();
		t_brown();
		tally_and_finish();
	end
endmodule
`default_nettype wire

// [tb/nvsc_sram_model.sv]
// Behavioural 8K x 8 nonvolatile SRAM on the far side of the host
`timescale 1ns/1ns
`default_nettype none
module nvsc_sram_model (
	input  wire logic                 supply_good,
	input  wire nvsc_pkg::nvsc_pins_t pins,
	input  wire logic [7:0]           host_d,
	input  wire logic                 host_oe,
	output logic [7:0]                bus
);
	logic [7:0] mem [8192];
	logic       drv;
	logic       drv_late;
	logic       wr;
	logic [7:0] q_late;
	assign drv = supply_good && !pins.select_n && !pins.enable_n && pins.strobe_n;
	assign wr = supply_good && !pins.select_n && !pins.strobe_n;
	assign #(150, 0) drv_late = drv;
	assign #150 q_late = mem[pins.byte_address];
	// A float shows the inverse byte so it never passes for the stored value
	assign bus = host_oe ? host_d : (drv_late ? q_late : ~mem[pins.byte_address]);
	always @(negedge wr) begin
		if (supply_good)
			mem[pins.byte_address] = host_d;
	end
endmodule
`default_nettype wire
